// ---- logic/eio_pkg.sv ----
// constants and types of the expansion i/o port block
// What this block does
// - four ports: three eight pins wide, the fourth three pins wide
// - each pin configured alone, by fixed configuration or software registers, except the macrocell clock select, which is shared per nibble
// - an assigned pin serves only its one function
// - output select from control register (first two ports) and fixed configuration
// - output sources: data-out, latched address, macrocell output, external chip select
// - readback presents exactly one selected source at a time
// - readback sources: data-out, macrocells, direction, control, live pin level
// - driver enable is array enable term or direction bit
// - without enable term or array output, direction bit alone drives enable
// - port registers writable and readable back for checking
// - wide ports have input macrocells: latch, register or pass-through
// - macrocell enable or clock selects address strobe or array term
// - macrocell outputs feed array input bus and are software readable
// - control bit zero puts pin in software i/o mode
// - software i/o output pin is driven by its data-out bit
// - one macrocell clock term per nibble of four pins
package eio_pkg;
    localparam int NPORT = 4;
    localparam int NWIDE = 3;
    localparam int PW = 8;
    localparam int PD_W = 3;
    localparam logic [7:0] REG_RST = 8'h00;
    // register byte address = {port, kind} * 4
    localparam logic [3:0] KIND_DOUT = 4'h0;
    localparam logic [3:0] KIND_DIR = 4'h1;
    localparam logic [3:0] KIND_CTRL = 4'h2;
    localparam logic [3:0] KIND_PIN = 4'h3;
    localparam logic [3:0] KIND_MCELL = 4'h4;
    localparam logic [3:0] KIND_IMC = 4'h5;
    localparam int KIND_LSB = 2;
    localparam int PORT_LSB = 6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        EIO_SRC_DOUT = 2'b00,
        EIO_SRC_ADDR = 2'b01,
        EIO_SRC_MCELL = 2'b10,
        EIO_SRC_XCS = 2'b11
    } eio_src_e;
    typedef enum logic [1:0] {
        EIO_IMC_PASS = 2'b00,
        EIO_IMC_LATCH = 2'b01,
        EIO_IMC_REG = 2'b10
    } eio_imc_e;
endpackage

// ---- logic/eio_imc.sv ----
// input macrocells of one eight pin port
`timescale 1ns/1ps
module eio_imc (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [7:0] pin_in,
    input wire logic [15:0] mode,
    input wire logic [1:0] clk_sel,
    input wire logic strobe,
    input wire logic [1:0] clk_term,
    output logic [7:0] imc_out
);
    logic [7:0] hold_ff;
    logic [7:0] nxt_hold;
    logic [1:0] en_prv_ff;
    logic [1:0] nxt_en_prv;
    logic [1:0] en;
    always_comb begin
        for (int n = 0; n < 2; n++) begin
            en[n] = clk_sel[n] ? clk_term[n] : strobe;
        end
        nxt_en_prv = en;
        nxt_hold = hold_ff;
        imc_out = '0;
        for (int i = 0; i < 8; i++) begin
            // sampled edge of the enable, not a gated clock, to stay single domain
            unique case (eio_pkg::eio_imc_e'(mode[2*i+:2]))
                eio_pkg::EIO_IMC_LATCH: begin
                    if (en[i/4]) nxt_hold[i] = pin_in[i];
                    imc_out[i] = en[i/4] ? pin_in[i] : hold_ff[i];
                end
                eio_pkg::EIO_IMC_REG: begin
                    if (en[i/4] && !en_prv_ff[i/4]) nxt_hold[i] = pin_in[i];
                    imc_out[i] = hold_ff[i];
                end
                default: imc_out[i] = pin_in[i];
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            hold_ff <= '0;
            en_prv_ff <= '0;
        end else if (ce) begin
            hold_ff <= nxt_hold;
            en_prv_ff <= nxt_en_prv;
        end
    end
endmodule

// ---- logic/eio_port.sv ----
// expansion i/o ports with axi4-lite register access
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module eio_port (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] cfg_src,
    input wire logic [31:0] cfg_oe_term_def,
    input wire logic [31:0] cfg_mcell_out,
    input wire logic [47:0] cfg_imc_mode,
    input wire logic [5:0] cfg_imc_clk_sel,
    input wire logic [31:0] pin_in,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe,
    input wire logic [15:0] latched_addr,
    input wire logic [31:0] mcell_in,
    input wire logic [31:0] xcs_in,
    input wire logic [31:0] oe_term,
    input wire logic address_latch_strobe,
    input wire logic [5:0] imc_clk_term,
    output logic [23:0] imc_bus
);
    // port d has three pins; upper five bits of every port d field stay zero
    localparam logic [31:0] PIN_MASK = 32'h07FFFFFF;
    logic [31:0] dout_ff, nxt_dout;
    logic [31:0] dir_ff, nxt_dir;
    logic [15:0] ctrl_ff, nxt_ctrl;
    logic [31:0] pin_s1_ff, pin_s2_ff;
    logic [5:0] als_s_ff;
    logic [31:0] pin_out_ff, nxt_pin_out;
    logic [31:0] pin_oe_ff, nxt_pin_oe;
    logic [23:0] imc_q;
    logic [23:0] imc_bus_ff;
    logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got, bvalid_ff, nxt_bvalid;
    logic [7:0] awaddr_ff, nxt_awaddr;
    logic [7:0] wdata_ff, nxt_wdata;
    logic wstrb_ff, nxt_wstrb;
    logic [1:0] bresp_ff, nxt_bresp;
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;
    logic do_wr, do_rd;

    function automatic logic addr_ok(input logic [7:0] a);
        logic [3:0] k;
        k = a[eio_pkg::KIND_LSB+:4];
        addr_ok = (k <= eio_pkg::KIND_IMC) && !(k == eio_pkg::KIND_CTRL && a[7])
            && !(k == eio_pkg::KIND_IMC && a[7:6] == 2'h3);
    endfunction

    genvar g;
    for (g = 0; g < eio_pkg::NWIDE; g++) begin : gen_imc
        eio_imc u_imc (
            .clk(clk),
            .reset(reset),
            .ce(ce),
            .pin_in(pin_s2_ff[8*g+:8]),
            .mode(cfg_imc_mode[16*g+:16]),
            .clk_sel(cfg_imc_clk_sel[2*g+:2]),
            .strobe(als_s_ff[5]),
            .clk_term(imc_clk_term[2*g+:2]),
            .imc_out(imc_q[8*g+:8])
        );
    end

    // pin drive: one source per pin, chosen by fixed config and control bit
    always_comb begin
        eio_pkg::eio_src_e src;
        src = eio_pkg::EIO_SRC_DOUT;
        nxt_pin_out = '0;
        nxt_pin_oe = '0;
        for (int i = 0; i < 32; i++) begin
            src = eio_pkg::eio_src_e'(cfg_src[i] ? 2'b10 : 2'b00);
            if (i < 16 && ctrl_ff[i]) src = eio_pkg::EIO_SRC_ADDR;
            if (cfg_mcell_out[i]) src = eio_pkg::EIO_SRC_MCELL;
            if (i >= 24 && cfg_src[i]) src = eio_pkg::EIO_SRC_XCS;
            unique case (src)
                eio_pkg::EIO_SRC_DOUT: nxt_pin_out[i] = dout_ff[i];
                eio_pkg::EIO_SRC_ADDR: nxt_pin_out[i] = latched_addr[i % 16];
                eio_pkg::EIO_SRC_MCELL: nxt_pin_out[i] = mcell_in[i];
                eio_pkg::EIO_SRC_XCS: nxt_pin_out[i] = xcs_in[i];
            endcase
            // with no term defined the direction bit alone decides
            nxt_pin_oe[i] = (cfg_oe_term_def[i] & oe_term[i]) | dir_ff[i];
        end
        nxt_pin_out = nxt_pin_out & PIN_MASK;
        nxt_pin_oe = nxt_pin_oe & PIN_MASK;
    end

    // axi write side: address and data may come in either order
    always_comb begin
        nxt_aw_got = aw_got_ff;
        nxt_w_got = w_got_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_dout = dout_ff;
        nxt_dir = dir_ff;
        nxt_ctrl = ctrl_ff;
        do_wr = aw_got_ff && w_got_ff && !bvalid_ff;
        if (s_axi_awvalid && !aw_got_ff && !bvalid_ff) begin
            nxt_aw_got = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_ff && !bvalid_ff) begin
            nxt_w_got = 1'b1;
            nxt_wdata = s_axi_wdata[7:0];
            nxt_wstrb = s_axi_wstrb[0];
        end
        if (do_wr) begin
            nxt_bvalid = 1'b1;
            nxt_aw_got = 1'b0;
            nxt_w_got = 1'b0;
            nxt_bresp = addr_ok(awaddr_ff) ? eio_pkg::RESP_OKAY : eio_pkg::RESP_SLVERR;
            if (addr_ok(awaddr_ff) && wstrb_ff) begin
                unique case (awaddr_ff[eio_pkg::KIND_LSB+:4])
                    eio_pkg::KIND_DOUT: nxt_dout[8*awaddr_ff[7:6]+:8] = wdata_ff;
                    eio_pkg::KIND_DIR: nxt_dir[8*awaddr_ff[7:6]+:8] = wdata_ff;
                    eio_pkg::KIND_CTRL: nxt_ctrl[8*awaddr_ff[6]+:8] = wdata_ff;
                    default: ;
                endcase
            end
            nxt_dout = nxt_dout & PIN_MASK;
            nxt_dir = nxt_dir & PIN_MASK;
        end
        if (bvalid_ff && s_axi_bready) nxt_bvalid = 1'b0;
    end

    // axi read side: one source per access onto the data word
    always_comb begin
        logic [31:0] sel;
        sel = '0;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        do_rd = s_axi_arvalid && !rvalid_ff;
        if (do_rd) begin
            unique case (s_axi_araddr[eio_pkg::KIND_LSB+:4])
                eio_pkg::KIND_DOUT: sel = dout_ff;
                eio_pkg::KIND_DIR: sel = dir_ff;
                eio_pkg::KIND_CTRL: sel = {16'h0000, ctrl_ff};
                eio_pkg::KIND_PIN: sel = pin_s2_ff & PIN_MASK;
                eio_pkg::KIND_MCELL: sel = mcell_in & PIN_MASK;
                eio_pkg::KIND_IMC: sel = {8'h00, imc_q};
                default: sel = '0;
            endcase
            nxt_rvalid = 1'b1;
            nxt_rdata = addr_ok(s_axi_araddr) ? {24'h000000, sel[8*s_axi_araddr[7:6]+:8]}
                                              : 32'h00000000;
            nxt_rresp = addr_ok(s_axi_araddr) ? eio_pkg::RESP_OKAY : eio_pkg::RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dout_ff <= {4{eio_pkg::REG_RST}};
            dir_ff <= {4{eio_pkg::REG_RST}};
            ctrl_ff <= {2{eio_pkg::REG_RST}};
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            als_s_ff <= '0;
            pin_out_ff <= '0;
            pin_oe_ff <= '0;
            imc_bus_ff <= '0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= '0;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= '0;
        end else if (ce) begin
            dout_ff <= nxt_dout;
            dir_ff <= nxt_dir;
            ctrl_ff <= nxt_ctrl;
            pin_s1_ff <= pin_in;
            pin_s2_ff <= pin_s1_ff;
            // strobe passes two flops; bit 5 is the synchronised copy
            als_s_ff <= {als_s_ff[4], address_latch_strobe, 4'h0};
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
            imc_bus_ff <= imc_q;
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    // readies stay low while a response waits, so only one write is under way
    assign s_axi_awready = !aw_got_ff && !bvalid_ff && ce && !reset;
    assign s_axi_wready = !w_got_ff && !bvalid_ff && ce && !reset;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rvalid_ff && ce && !reset;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign pin_out = pin_out_ff;
    assign pin_oe = pin_oe_ff;
    assign imc_bus = imc_bus_ff;
endmodule

// ---- tb/eio_port_properties.sv ----
// port-level assertions for the expansion i/o port
`timescale 1ns/1ps
module eio_port_properties (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] cfg_oe_term_def,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] oe_term
);
    default clocking @(posedge clk); endclocking
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wr_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    AST_WR_LAT: assert property (disable iff (reset) wr_taken |=> wr_answer)
        else $error("write answer not two edges after take");
    AST_RD_LAT: assert property (disable iff (reset)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_B_HOLD: assert property (disable iff (reset)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    AST_R_HOLD: assert property (disable iff (reset)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    AST_ONE_OUT: assert property (disable iff (reset)
        (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        and (s_axi_rvalid |-> !s_axi_arready))
        else $error("request taken while answer pending");
    AST_RST_CLR: assert property (reset && ce |=>
        pin_out == 32'h00000000 && pin_oe == 32'h00000000 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("reset did not clear outputs");
    AST_RST_RDY: assert property (reset |->
        !s_axi_awready && !s_axi_wready && !s_axi_arready)
        else $error("ready during reset");
    AST_NARROW: assert property (disable iff (reset)
        pin_out[31:27] == 5'h00 && pin_oe[31:27] == 5'h00)
        else $error("unused pin bits active");
    AST_OE_TERM: assert property (disable iff (reset)
        ce |=> (pin_oe[26:0] & $past(oe_term[26:0] & cfg_oe_term_def[26:0]))
            == $past(oe_term[26:0] & cfg_oe_term_def[26:0]))
        else $error("enable term did not turn driver on");
endmodule
bind eio_port eio_port_properties u_eio_port_properties (.clk, .reset, .ce, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .cfg_oe_term_def, .pin_out, .pin_oe, .oe_term);

// ---- tb/eio_pin_env.sv ----
// pin side stand-in: each pin shows the port drive or the outside circuit level
`timescale 1ns/1ps
module eio_pin_env (
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] ext_level,
    output logic [31:0] pin_in
);
    // no bus keeper: an undriven pin follows the outside level, never the old drive
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ---- tb/eio_port_tb.sv ----
// register-level testbench for the expansion i/o port
`timescale 1ns/1ps
module eio_port_tb;
    logic clk, reset, ce, address_latch_strobe;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] cfg_src, cfg_oe_term_def, cfg_mcell_out, pin_in, pin_out, pin_oe;
    logic [31:0] mcell_in, xcs_in, oe_term, ext_level;
    logic [47:0] cfg_imc_mode;
    logic [5:0] cfg_imc_clk_sel, imc_clk_term;
    logic [15:0] latched_addr;
    logic [23:0] imc_bus;
    int err_count, comparisons;
    eio_port u_eio_port (.clk, .reset, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg_src, .cfg_oe_term_def,
        .cfg_mcell_out, .cfg_imc_mode, .cfg_imc_clk_sel, .pin_in, .pin_out, .pin_oe,
        .latched_addr, .mcell_in, .xcs_in, .oe_term, .address_latch_strobe, .imc_clk_term,
        .imc_bus);
    eio_pin_env u_eio_pin_env (.pin_out, .pin_oe, .ext_level, .pin_in);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] ad(input int p, input int k);
        return 8'(p * 64 + k * 4);
    endfunction
    // outputs are read before this edge's updates land: two edges cover one register stage
    task automatic settle;
        repeat (2) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input int p, input int k, input logic [7:0] ev, input logic [1:0] er);
        s_axi_araddr <= ad(p, k);
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk);
        chk("rdata", {24'h000000, ev}, d);
        chk("rresp", {30'h00000000, er}, {30'h00000000, r});
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        conclude();
    end
    initial begin
        reset = 1'b1;
        ce = 1'b1;
        s_axi_wstrb = 4'hF;
        latched_addr = 16'h3C96;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, address_latch_strobe} = '0;
        {cfg_src, cfg_oe_term_def, cfg_mcell_out, mcell_in, xcs_in, oe_term, ext_level} = '0;
        {cfg_imc_mode, cfg_imc_clk_sel, imc_clk_term} = '0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        // control register exists on the first two ports only
        for (int p = 0; p < 4; p++)
            for (int k = 0; k < 3; k++)
                rdc(p, k, 8'h00, (k == 2 && p > 1) ? 2'h2 : 2'h0);
        $display("test reset done");
        wr(ad(0, 0), 8'hA5);
        chk("bresp", 32'h0, {30'h0, r});
        wr(ad(0, 1), 8'hFF);
        rdc(0, 0, 8'hA5, 2'h0);
        rdc(0, 1, 8'hFF, 2'h0);
        chk("pin_out", 32'hA5, {24'h0, pin_out[7:0]});
        chk("pin_oe", 32'hFF, {24'h0, pin_oe[7:0]});
        rdc(0, 3, 8'hA5, 2'h0);
        wr(ad(0, 2), 8'hFF);
        settle();
        chk("pin_out", 32'h96, {24'h0, pin_out[7:0]});
        rdc(0, 2, 8'hFF, 2'h0);
        wr(ad(0, 2), 8'h00);
        settle();
        chk("pin_out", 32'hA5, {24'h0, pin_out[7:0]});
        $display("test readback done");
        cfg_oe_term_def <= 32'h00000100;
        oe_term <= 32'h00000100;
        settle();
        chk("pin_oe", 32'h01, {24'h0, pin_oe[15:8]});
        // terms stay high on the whole port: without a defined term they must not count
        cfg_oe_term_def <= 32'h00000000;
        oe_term <= 32'h0000FF00;
        wr(ad(1, 1), 8'h0F);
        settle();
        chk("pin_oe", 32'h0F, {24'h0, pin_oe[15:8]});
        wr(ad(1, 1), 8'h00);
        cfg_mcell_out <= 32'h00FF0000;
        mcell_in <= 32'h005A0000;
        cfg_src <= 32'h07000000;
        xcs_in <= 32'h05000000;
        settle();
        chk("pin_out", 32'h55A, {21'h0, pin_out[26:16]});
        rdc(2, 4, 8'h5A, 2'h0);
        $display("test output select done");
        cfg_mcell_out <= 32'h00000000;
        ext_level <= 32'h00C3E700;
        settle();
        settle();
        chk("imc_bus", 32'hC3, {24'h0, imc_bus[23:16]});
        rdc(2, 5, 8'hC3, 2'h0);
        rdc(2, 3, 8'hC3, 2'h0);
        // port A registers, port B latches; A low nibble clocked by the array term
        cfg_imc_mode <= {16'h0000, 16'h5555, 16'hAAAA};
        cfg_imc_clk_sel <= 6'b000001;
        imc_clk_term <= 6'h01;
        settle();
        imc_clk_term <= 6'h00;
        settle();
        chk("imc_bus", 32'h5, {28'h0, imc_bus[3:0]});
        wr(ad(0, 0), 8'h3C);
        address_latch_strobe <= 1'b1;
        settle();
        address_latch_strobe <= 1'b0;
        settle();
        ext_level <= 32'h00C31800;
        settle();
        chk("imc_bus", 32'hE735, {16'h0, imc_bus[15:0]});
        $display("test input macrocell done");
        rdc(3, 5, 8'h00, 2'h2);
        wr(ad(3, 5), 8'h11);
        chk("bresp", 32'h2, {30'h0, r});
        $display("test unmapped done");
        conclude();
    end
endmodule
